// File: rtl/sfr_defs.svh
// constants of the flash register and read command block
// assumes inclusion by bare name from sfr_core
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
// command codes
`define SFR_OP_WR_STATUS    8'h01
`define SFR_OP_WR_STATUS_HI 8'h31
`define SFR_OP_WR_CONFIG    8'h11
`define SFR_OP_RD_STATUS_LO 8'h05
`define SFR_OP_RD_STATUS_HI 8'h35
`define SFR_OP_RD_CONFIG    8'h15
`define SFR_OP_READ         8'h03
`define SFR_OP_FAST         8'h0B
`define SFR_OP_DUAL         8'h3B
`define SFR_OP_WR_ENABLE    8'h06
`define SFR_OP_WR_DISABLE   8'h04
// frame lengths in serial clocks
`define SFR_CMD_BITS        8
`define SFR_ADDR_BITS       24
`define SFR_BYTE_BITS       8
`define SFR_WORD_BITS       16
`define SFR_SPI_DUMMY       8
// dummy clocks chosen by the dummy count select and read parameters
`define SFR_DUAL_IO_DUMMY0  4'h4
`define SFR_DUAL_IO_DUMMY1  4'h8
`define SFR_QUAD_IO_DUMMY0  4'h6
`define SFR_QUAD_IO_DUMMY1  4'hA
`define SFR_QCM_DUMMY0      4'h4
`define SFR_QCM_DUMMY1      4'h6
`define SFR_QCM_DUMMY2      4'h8
// reset values
`define SFR_STATUS_RST      16'h0000
`define SFR_CONFIG_RST      8'h00
// synchroniser idle: select high, clock low, protect high, data high
`define SFR_SYNC_RST        4'hB
// register write time in microseconds and clock rate in MHz
`define SFR_TW_US           5
`define SFR_CLK_MHZ         250
`endif

// File: rtl/sfr_pkg.sv
// types of the flash register and read command block
// assumes sfr_defs.svh alongside
package sfr_pkg;
  // status word, top bit first
  typedef struct packed {
    logic       suspend_flag;
    logic       protect_complement;
    logic [2:0] security_lock_bits;
    logic       program_erase_fail_flag;
    logic       quad_enable;
    logic       status_protect_high;
    logic       status_protect_low;
    logic [4:0] block_protect_bits;
    logic       write_enable_latch;
    logic       write_in_progress;
  } sfr_status_t;
  // configuration byte, top bit first
  typedef struct packed {
    logic       hold_reset_select;
    logic [3:0] reserved_hi;
    logic       protect_scheme_select;
    logic       dummy_count_select;
    logic       reserved_lo;
  } sfr_config_t;
  // serial engine states, gray along the usual path
  typedef enum logic [2:0] {
    SFR_IDLE  = 3'h0,
    SFR_CMD   = 3'h1,
    SFR_ADDR  = 3'h3,
    SFR_DUMMY = 3'h2,
    SFR_OUT   = 3'h6,
    SFR_WDATA = 3'h7,
    SFR_SKIP  = 3'h5
  } sfr_state_t;
endpackage

// File: rtl/sfr_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes clk domain with synchronous active high reset
`timescale 1ns/1ns
module sfr_sync #(
  parameter int         W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST;
      sync_q <= RST;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end
  assign sync = sync_q;
endmodule

// File: rtl/sfr_timer.sv
// self-timed register write cycle counter
// assumes a one-cycle start pulse on clk
`timescale 1ns/1ns
module sfr_timer #(
  parameter int CYCLES = 1250
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // load on start, count down to zero
  always_comb
  begin
    cnt_d = cnt_q;
    if (start)
      cnt_d = CW'(CYCLES);
    else if (cnt_q != '0)
      cnt_d = cnt_q - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
  assign busy = (cnt_q != '0);
  assign done = (cnt_q == CW'(1));
endmodule

// File: rtl/sfr_core.sv
// serial flash status, configuration and array read command engine
// assumes host drives cs_n, sclk (mode 0) and io0; array read on clk
`timescale 1ns/1ns
`include "sfr_defs.svh"
module sfr_core
  import sfr_pkg::*;
#(
  parameter int ADDR_W    = 24,
  parameter int TW_CYCLES = `SFR_TW_US * `SFR_CLK_MHZ
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic [3:0]        io_i,
  output logic      [3:0]        io_o,
  output logic      [3:0]        io_oe,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              pe_busy,
  input  wire logic              pe_fail,
  input  wire logic              pe_pass,
  input  wire logic              suspend_evt,
  input  wire logic              resume_evt,
  input  wire logic              quad_command_mode,
  input  wire logic [1:0]        read_param,
  output sfr_status_t            status_word,
  output sfr_config_t            configuration_byte,
  output logic                   pin_is_hold,
  output logic                   pin_is_reset,
  output logic                   block_lock_scheme,
  output logic                   pe_permit,
  output logic      [3:0]        dual_io_dummy,
  output logic      [3:0]        quad_io_dummy
);
  ////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [3:0] pin_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       wp_n_s;
  logic       si_s;

  sfr_sync #(.W(4), .RST(`SFR_SYNC_RST)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .pin  ({cs_n_i, sclk_i, io_i[2], io_i[0]}),
    .sync (pin_s)
  );
  assign cs_n_s = pin_s[3];
  assign sclk_s = pin_s[2];
  assign wp_n_s = pin_s[1];
  assign si_s   = pin_s[0]; // io1 and io3 never sampled

  ////////////////////////////////////////////////////////////////////
  // register write cycle timer
  logic tw_start;
  logic tw_busy;
  logic tw_done;

  sfr_timer #(.CYCLES(TW_CYCLES)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (tw_start),
    .busy  (tw_busy),
    .done  (tw_done)
  );

  ////////////////////////////////////////////////////////////////////
  // helpers
  sfr_status_t sts_q;
  sfr_status_t sts_d;
  sfr_config_t cfg_q;
  sfr_config_t cfg_d;
  logic        busy;
  logic        hw_protect;

  // fast read dummy clocks in quad command mode
  function automatic logic [3:0] qcm_dummy(input logic [1:0] p);
    unique case (p)
      2'h0:    qcm_dummy = `SFR_QCM_DUMMY0;
      2'h1:    qcm_dummy = `SFR_QCM_DUMMY1;
      default: qcm_dummy = `SFR_QCM_DUMMY2;
    endcase
  endfunction

  assign busy       = tw_busy | pe_busy;
  // protect pin only exists while quad is off
  assign hw_protect = sts_q.status_protect_high |
                      (sts_q.status_protect_low & ~wp_n_s & ~sts_q.quad_enable);
  assign pe_permit  = sts_q.write_enable_latch & ~busy;

  // pin function and protect scheme decode
  assign pin_is_hold       = ~sts_q.quad_enable & ~cfg_q.hold_reset_select;
  assign pin_is_reset      = ~sts_q.quad_enable & cfg_q.hold_reset_select;
  assign block_lock_scheme = cfg_q.protect_scheme_select;
  assign dual_io_dummy     = cfg_q.dummy_count_select ? `SFR_DUAL_IO_DUMMY1
                                                      : `SFR_DUAL_IO_DUMMY0;
  assign quad_io_dummy     = cfg_q.dummy_count_select ? `SFR_QUAD_IO_DUMMY1
                                                      : `SFR_QUAD_IO_DUMMY0;

  ////////////////////////////////////////////////////////////////////
  // serial engine
  sfr_state_t        st_q;
  sfr_state_t        st_d;
  logic              cs_prev_q;
  logic              sclk_prev_q;
  logic [4:0]        cnt_q;
  logic [4:0]        cnt_d;
  logic [3:0]        dum_q;
  logic [3:0]        dum_d;
  logic [7:0]        op_q;
  logic [7:0]        op_d;
  logic [23:0]       sh_q;
  logic [23:0]       sh_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [7:0]        obuf_q;
  logic [7:0]        obuf_d;
  logic [3:0]        obit_q;
  logic [3:0]        obit_d;
  logic [1:0]        io_q;
  logic [1:0]        io_d;
  logic [4:0]        wcnt_q;
  logic [4:0]        wcnt_d;
  logic [15:0]       wdat_q;
  logic [15:0]       wdat_d;
  logic              wel_set;
  logic              wel_clr;
  logic              wr_lo;
  logic              wr_hi;
  logic              wr_cfg;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              dual;
  logic              wr_ok;
  logic [7:0]        src;
  logic [7:0]        w_lo;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cs_fall   = ~cs_n_s & cs_prev_q;
  assign cs_rise   = cs_n_s & ~cs_prev_q;
  assign dual      = (op_q == `SFR_OP_DUAL);
  assign wr_ok     = sts_q.write_enable_latch & ~busy & ~hw_protect;
  assign w_lo      = (wcnt_q == 5'(`SFR_WORD_BITS)) ? wdat_q[15:8] : wdat_q[7:0];

  // byte source for the output phase
  always_comb
  begin
    unique case (op_q)
      `SFR_OP_RD_STATUS_LO: src = status_word[7:0];
      `SFR_OP_RD_STATUS_HI: src = status_word[15:8];
      `SFR_OP_RD_CONFIG:    src = configuration_byte;
      default:              src = mem_rdata;
    endcase
  end

  // next state of the serial engine
  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    dum_d   = dum_q;
    op_d    = op_q;
    sh_d    = sh_q;
    addr_d  = addr_q;
    obuf_d  = obuf_q;
    obit_d  = obit_q;
    io_d    = io_q;
    wcnt_d  = wcnt_q;
    wdat_d  = wdat_q;
    wel_set = 1'b0;
    wel_clr = 1'b0;
    wr_lo   = 1'b0;
    wr_hi   = 1'b0;
    wr_cfg  = 1'b0;
    if (cs_n_s)
    begin
      st_d = SFR_IDLE;
      // frame end: commit a register write only at a byte boundary
      if (cs_rise && st_q == SFR_WDATA && wr_ok)
      begin
        unique case (op_q)
          `SFR_OP_WR_STATUS:
          begin
            wr_lo = (wcnt_q == 5'(`SFR_BYTE_BITS)) ||
                    (wcnt_q == 5'(`SFR_WORD_BITS));
            wr_hi = (wcnt_q == 5'(`SFR_WORD_BITS));
          end
          `SFR_OP_WR_STATUS_HI: wr_hi = (wcnt_q == 5'(`SFR_BYTE_BITS));
          default:              wr_cfg = (wcnt_q == 5'(`SFR_BYTE_BITS));
        endcase
      end
    end
    else if (cs_fall)
    begin
      st_d   = SFR_CMD;
      cnt_d  = '0;
      obit_d = '0;
      io_d   = '0;
    end
    else if (sclk_rise)
    begin
      sh_d  = {sh_q[22:0], si_s};
      cnt_d = cnt_q + 5'(1);
      unique case (st_q)
        SFR_CMD:
          if (cnt_q == 5'(`SFR_CMD_BITS - 1))
          begin
            op_d  = sh_d[7:0];
            cnt_d = '0;
            unique case (sh_d[7:0])
              `SFR_OP_READ:
                st_d = SFR_ADDR;
              `SFR_OP_FAST, `SFR_OP_DUAL:
                st_d = busy ? SFR_SKIP : SFR_ADDR;
              `SFR_OP_RD_STATUS_LO, `SFR_OP_RD_STATUS_HI, `SFR_OP_RD_CONFIG:
                st_d = SFR_OUT;
              `SFR_OP_WR_STATUS, `SFR_OP_WR_STATUS_HI, `SFR_OP_WR_CONFIG:
              begin
                st_d   = SFR_WDATA;
                wcnt_d = '0;
              end
              `SFR_OP_WR_ENABLE:
              begin
                wel_set = 1'b1;
                st_d    = SFR_SKIP;
              end
              `SFR_OP_WR_DISABLE:
              begin
                wel_clr = 1'b1;
                st_d    = SFR_SKIP;
              end
              default: st_d = SFR_SKIP;
            endcase
          end
        SFR_ADDR:
          if (cnt_q == 5'(`SFR_ADDR_BITS - 1))
          begin
            addr_d = sh_d[ADDR_W-1:0];
            cnt_d  = '0;
            if (op_q == `SFR_OP_READ)
              st_d = SFR_OUT;
            else
            begin
              st_d  = SFR_DUMMY;
              dum_d = (quad_command_mode && !dual) ? qcm_dummy(read_param)
                                                   : 4'(`SFR_SPI_DUMMY);
            end
          end
        SFR_DUMMY:
          if (cnt_q == 5'(dum_q - 4'(1)))
            st_d = SFR_OUT;
        SFR_WDATA:
        begin
          wdat_d = {wdat_q[14:0], si_s};
          if (wcnt_q <= 5'(`SFR_WORD_BITS))
            wcnt_d = wcnt_q + 5'(1); // stops one past a word
        end
        default: ;
      endcase
    end
    else if (sclk_fall && st_q == SFR_OUT)
    begin
      // shift out on falling edges, fresh byte when empty
      if (obit_q == '0)
      begin
        if (dual)
        begin
          io_d   = src[7:6];
          obuf_d = {src[5:0], 2'h0};
          obit_d = 4'h6;
        end
        else
        begin
          io_d   = {src[7], 1'b0};
          obuf_d = {src[6:0], 1'b0};
          obit_d = 4'h7;
        end
        if (op_q == `SFR_OP_READ || op_q == `SFR_OP_FAST || dual)
          addr_d = addr_q + ADDR_W'(1);
      end
      else if (dual)
      begin
        io_d   = obuf_q[7:6];
        obuf_d = {obuf_q[5:0], 2'h0};
        obit_d = obit_q - 4'h2;
      end
      else
      begin
        io_d   = {obuf_q[7], 1'b0};
        obuf_d = {obuf_q[6:0], 1'b0};
        obit_d = obit_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q        <= SFR_IDLE;
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
      cnt_q       <= '0;
      dum_q       <= '0;
      op_q        <= '0;
      sh_q        <= '0;
      addr_q      <= '0;
      obuf_q      <= '0;
      obit_q      <= '0;
      io_q        <= '0;
      wcnt_q      <= '0;
      wdat_q      <= '0;
    end
    else
    begin
      st_q        <= st_d;
      cs_prev_q   <= cs_n_s;
      sclk_prev_q <= sclk_s;
      cnt_q       <= cnt_d;
      dum_q       <= dum_d;
      op_q        <= op_d;
      sh_q        <= sh_d;
      addr_q      <= addr_d;
      obuf_q      <= obuf_d;
      obit_q      <= obit_d;
      io_q        <= io_d;
      wcnt_q      <= wcnt_d;
      wdat_q      <= wdat_d;
    end
  end

  assign tw_start = wr_lo | wr_hi | wr_cfg;
  assign mem_addr = addr_q;
  assign io_o     = {2'h0, io_q};
  assign io_oe    = {2'h0, st_q == SFR_OUT, st_q == SFR_OUT && dual};

  ////////////////////////////////////////////////////////////////////
  // status word and configuration byte
  always_comb
  begin
    sfr_status_t w;
    w     = sfr_status_t'({wdat_q[7:0], w_lo});
    sts_d = sts_q;
    cfg_d = cfg_q;
    // top, fail, latch and busy positions are never taken from data
    if (wr_hi)
    begin
      sts_d.protect_complement  = w.protect_complement;
      sts_d.security_lock_bits  = sts_q.security_lock_bits |
                                  w.security_lock_bits;
      sts_d.quad_enable         = w.quad_enable;
      sts_d.status_protect_high = w.status_protect_high;
    end
    if (wr_lo)
    begin
      sts_d.status_protect_low = w.status_protect_low;
      sts_d.block_protect_bits = w.block_protect_bits;
    end
    if (wr_cfg)
    begin
      cfg_d.hold_reset_select     = wdat_q[7];
      cfg_d.protect_scheme_select = wdat_q[2];
      cfg_d.dummy_count_select    = wdat_q[1];
    end
    // events win over their clears
    if (pe_pass)
      sts_d.program_erase_fail_flag = 1'b0;
    if (pe_fail)
      sts_d.program_erase_fail_flag = 1'b1;
    if (resume_evt)
      sts_d.suspend_flag = 1'b0;
    if (suspend_evt)
      sts_d.suspend_flag = 1'b1;
    if (tw_done || wel_clr)
      sts_d.write_enable_latch = 1'b0;
    if (wel_set)
      sts_d.write_enable_latch = 1'b1;
    sts_d.write_in_progress = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sts_q <= sfr_status_t'(`SFR_STATUS_RST);
      cfg_q <= sfr_config_t'(`SFR_CONFIG_RST);
    end
    else
    begin
      sts_q <= sts_d;
      cfg_q <= cfg_d;
    end
  end

  // busy flag reflects the live write cycle
  always_comb
  begin
    status_word                   = sts_q;
    status_word.write_in_progress = busy;
  end
  assign configuration_byte = cfg_q;
endmodule

// File: verification/sfr_core_assertions.sv
// checker for the flash register and read command engine
// assumes bind onto sfr_core; clk domain, rst synchronous active high
`timescale 1ns/1ns
module sfr_core_assertions
  import sfr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  io_oe,
  input wire logic        pe_busy,
  input wire logic        pe_fail,
  input wire logic        pe_pass,
  input wire logic        suspend_evt,
  input wire logic        resume_evt,
  input wire sfr_status_t status_word,
  input wire sfr_config_t configuration_byte,
  input wire logic        pin_is_hold,
  input wire logic        pin_is_reset,
  input wire logic        block_lock_scheme,
  input wire logic        pe_permit,
  input wire logic [3:0]  dual_io_dummy,
  input wire logic [3:0]  quad_io_dummy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // flag events reach the status word within a few cycles
  property p_fail_set;
    pe_fail && !pe_pass |-> ##[1:3] status_word.program_erase_fail_flag;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not set");
  property p_fail_clr;
    pe_pass && !pe_fail |-> ##[1:3] !status_word.program_erase_fail_flag;
  endproperty
  a_fail_clr: assert property (p_fail_clr) else $error("fail flag not cleared");
  property p_sus_set;
    suspend_evt && !resume_evt |-> ##[1:3] status_word.suspend_flag;
  endproperty
  a_sus_set: assert property (p_sus_set) else $error("suspend flag not set");
  property p_sus_clr;
    resume_evt && !suspend_evt |-> ##[1:3] !status_word.suspend_flag;
  endproperty
  a_sus_clr: assert property (p_sus_clr) else $error("suspend flag not cleared");
  ////////////////////////////////////////////////////////////////////////////
  // decodes of the configuration byte
  property p_dummy;
    $stable(configuration_byte) |->
      dual_io_dummy == (configuration_byte.dummy_count_select ? 4'h8 : 4'h4) &&
      quad_io_dummy == (configuration_byte.dummy_count_select ? 4'hA : 4'h6);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy count wrong");
  property p_pin;
    $stable(configuration_byte) && $stable(status_word.quad_enable) |->
      pin_is_reset == (!status_word.quad_enable && configuration_byte.hold_reset_select) &&
      pin_is_hold == (!status_word.quad_enable && !configuration_byte.hold_reset_select);
  endproperty
  a_pin: assert property (p_pin) else $error("pin function wrong");
  property p_scheme;
    $stable(configuration_byte) |->
      block_lock_scheme == configuration_byte.protect_scheme_select;
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme select wrong");
  ////////////////////////////////////////////////////////////////////////////
  // latch, busy and output lines
  property p_permit;
    pe_permit == (status_word.write_enable_latch && !status_word.write_in_progress);
  endproperty
  a_permit: assert property (p_permit) else $error("permit wrong");
  property p_wel_clr;
    $fell(status_word.write_in_progress) && !$past(pe_busy) && !pe_busy
      |-> ##[0:2] !status_word.write_enable_latch;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch kept after cycle");
  property p_upper;
    io_oe[3:2] == 2'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper lines driven");
  property p_dual;
    io_oe[0] |-> io_oe[1];
  endproperty
  a_dual: assert property (p_dual) else $error("dual low line alone");
  cover property (status_word.write_in_progress && !pe_busy);
  cover property (io_oe[0]);
  cover property (status_word.suspend_flag);
endmodule
bind sfr_core sfr_core_assertions u_chk (
  .clk(clk), .rst(rst), .io_oe(io_oe), .pe_busy(pe_busy), .pe_fail(pe_fail),
  .pe_pass(pe_pass), .suspend_evt(suspend_evt), .resume_evt(resume_evt),
  .status_word(status_word), .configuration_byte(configuration_byte),
  .pin_is_hold(pin_is_hold), .pin_is_reset(pin_is_reset),
  .block_lock_scheme(block_lock_scheme), .pe_permit(pe_permit),
  .dual_io_dummy(dual_io_dummy), .quad_io_dummy(quad_io_dummy));

// File: verification/sfr_host.sv
// host serial controller model, mode 0, 125 ns serial clock
// assumes the bench resolves the io wires; clock rests low between frames
`timescale 1ns/1ns
module sfr_host (
  output logic            cs_n,
  output logic            sclk,
  output logic            si,
  input  wire logic [1:0] so,
  input  wire logic       so_oe
);
  logic saw_oe;
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
    saw_oe = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame: ntx bits msb first, then nrx clocks sampled on rising edge
  task automatic frame(input logic [47:0] tx, input int ntx, input int nrx,
                       input bit dl, output logic [15:0] rx);
    rx = '0;
    saw_oe = 1'h0;
    cs_n = 1'h0;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      si = (i < ntx) ? tx[ntx-1-i] : ~si; // released line toggles
      #62 sclk = 1'h1;
      if (i >= ntx)
        rx = dl ? {rx[13:0], so} : {rx[14:0], so[1]};
      saw_oe |= so_oe;
      #63 sclk = 1'h0;
    end
    #20 cs_n = 1'h1;
    si = ~si;
    #40;
  endtask
endmodule

// File: verification/sfr_core_bench.sv
// self-checking bench for the flash register and read command engine
// assumes sfr_host as far side, array byte = address xor A5
`timescale 1ns/1ns
module sfr_core_bench;
  import sfr_pkg::*;
  logic clk, rst, wp_n, pe_busy, pe_fail, pe_pass, suspend_evt, resume_evt, qcm;
  logic [1:0]  read_param;
  logic        cs_n, sclk, si;
  logic [3:0]  io_o, io_oe, dual_io_dummy, quad_io_dummy, io_i;
  logic [7:0]  mem_addr;
  sfr_status_t status_word;
  sfr_config_t configuration_byte;
  logic        pin_is_hold, pin_is_reset, block_lock_scheme, pe_permit;
  logic [15:0] rx, mid;
  logic [1:0]  so_w;
  int          num_errors, total_checks, cyc;
  // io0 resolved from the device enable; hold line pulled up
  assign io_i = {1'h1, wp_n, io_o[1], io_oe[0] ? io_o[0] : si};
  // released output lines show the inverse so stale data cannot pass
  assign so_w = {io_oe[1] ? io_o[1] : ~io_o[1], io_oe[0] ? io_o[0] : ~io_o[0]};
  sfr_core #(.ADDR_W(8), .TW_CYCLES(20)) dut (
    .clk(clk), .rst(rst), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_i), .io_o(io_o),
    .io_oe(io_oe), .mem_addr(mem_addr), .mem_rdata(mem_addr ^ 8'hA5),
    .pe_busy(pe_busy), .pe_fail(pe_fail), .pe_pass(pe_pass),
    .suspend_evt(suspend_evt), .resume_evt(resume_evt), .quad_command_mode(qcm),
    .read_param(read_param), .status_word(status_word),
    .configuration_byte(configuration_byte), .pin_is_hold(pin_is_hold),
    .pin_is_reset(pin_is_reset), .block_lock_scheme(block_lock_scheme),
    .pe_permit(pe_permit), .dual_io_dummy(dual_io_dummy), .quad_io_dummy(quad_io_dummy));
  sfr_host h (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_w), .so_oe(io_oe[1]));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare and frame helpers
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nd);
    h.frame({op, d} >> (16 - nd), 8 + nd, 0, 1'h0, rx);
    mid = status_word;
    repeat (40) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd,
                    input int nrx, input bit dl);
    h.frame({op, a} << nd, 32 + nd, nrx, dl, rx);
  endtask
  task automatic evt(input logic [3:0] v);
    @(negedge clk) {pe_fail, pe_pass, suspend_evt, resume_evt} = v;
    @(negedge clk) {pe_fail, pe_pass, suspend_evt, resume_evt} = 4'h0;
    repeat (4) @(negedge clk);
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    {clk, wp_n, pe_busy, pe_fail, pe_pass, suspend_evt, resume_evt, qcm} = 8'h40;
    {rst, read_param, num_errors, total_checks, cyc} = '0;
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    chk("status", 16'h0000, status_word);
    h.frame(8'h15, 8, 8, 1'h0, rx);
    chk("config", 16'h0000, rx);
    chk("dummy", 16'h0046, {dual_io_dummy, quad_io_dummy});
    chk("pins", 16'h0004, {pin_is_hold, pin_is_reset, block_lock_scheme});
    wr(8'h01, 16'hFF00, 8);
    chk("no_latch", 16'h0000, status_word);
    $display("test reset done");
    wr(8'h06, 16'h0000, 0);
    chk("latch", 16'h0002, status_word);
    wr(8'h01, 16'h7CFC, 16);
    chk("busy", 16'h0001, {15'h0, mid[0]});
    chk("two_byte", 16'h787C, status_word);
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'h0000, 8);
    chk("one_byte", 16'h7800, status_word);
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'hFFFF, 12);
    chk("bad_count", 16'h7802, mid);
    $display("test status write done");
    wr(8'h06, 16'h0000, 0);
    wr(8'h11, 16'h8600, 8);
    chk("config", 16'h0086, configuration_byte);
    chk("pins", 16'h0003, {pin_is_hold, pin_is_reset, block_lock_scheme});
    chk("dummy", 16'h008A, {dual_io_dummy, quad_io_dummy});
    h.frame(8'h15, 8, 8, 1'h0, rx);
    chk("config_rd", 16'h0086, rx);
    $display("test config done");
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'h8000, 8);
    @(negedge clk) wp_n = 1'h0;
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'h0000, 8);
    chk("hw_prot", 16'h7882, status_word);
    wr(8'h11, 16'h0000, 8);
    chk("hw_prot_cfg", 16'h0086, configuration_byte);
    @(negedge clk) wp_n = 1'h1;
    wr(8'h01, 16'h0000, 8);
    wr(8'h06, 16'h0000, 0);
    wr(8'h31, 16'h0000, 8);
    chk("locks_kept", 16'h3800, status_word);
    $display("test protect done");
    rd(8'h03, 24'h0000FF, 0, 16, 1'h0);
    chk("read_wrap", 16'h5AA5, rx);
    rd(8'h0B, 24'h000010, 8, 8, 1'h0);
    chk("fast", 16'h00B5, rx);
    rd(8'h3B, 24'h000020, 8, 4, 1'h1);
    chk("dual", 16'h0085, rx);
    qcm = 1'h1;
    for (int p = 0; p < 4; p++)
    begin
      @(negedge clk) read_param = p[1:0];
      rd(8'h0B, 24'h000030 + p, (p == 0) ? 4 : (p == 1) ? 6 : 8, 8, 1'h0);
      chk("qcm_fast", (16'h0030 + p) ^ 16'h00A5, rx);
    end
    @(negedge clk) qcm = 1'h0;
    $display("test reads done");
    @(negedge clk) pe_busy = 1'h1;
    @(negedge clk) chk("busy_flag", 16'h0001, {15'h0, status_word.write_in_progress});
    h.frame(8'h15, 8, 8, 1'h0, rx);
    chk("config_busy", 16'h0086, rx);
    rd(8'h0B, 24'h000010, 8, 8, 1'h0);
    chk("fast_refused", 16'h0000, {15'h0, h.saw_oe});
    rd(8'h3B, 24'h000010, 8, 4, 1'h1);
    chk("dual_refused", 16'h0000, {15'h0, h.saw_oe});
    @(negedge clk) pe_busy = 1'h0;
    evt(4'h8);
    chk("fail_set", 16'h3C00, status_word);
    evt(4'h4);
    chk("fail_clr", 16'h3800, status_word);
    evt(4'h2);
    chk("sus_set", 16'hB800, status_word);
    evt(4'h1);
    chk("sus_clr", 16'h3800, status_word);
    $display("test busy and events done");
    end_of_test();
  end
endmodule
